// *** core/block_copy_pkg.sv ***
// Package: constants and carrier types for the block copy and fill engine
package block_copy_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 36;  // Physical address width
  localparam int DATA_W      = 64;  // One doubleword
  localparam int BLOCK_BYTES = 32;
  localparam int BEATS       = 4;   // Doublewords per block
  localparam int BEAT_W      = 2;
  localparam int OFFSET_BITS = 5;   // Block offset bits ignored
  localparam int DW_BITS     = 3;   // Doubleword offset bits
  localparam int RBUF_DEPTH  = 4;   // Read buffer depth

  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [DW_BITS-1:0] DW_ZERO  = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Command from the processor side, one store_alternate_instr each
  typedef struct packed {
    logic              fill;       // 1: block fill, 0: block copy
    logic              src_cache;  // Copy source is the cache
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [DATA_W-1:0] pattern;    // Fill doubleword
  } cmd_type;

  // Request on the system bus side
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_req_type;

  // Engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RD_REQ  = 6'h02,
    ST_RD_WAIT = 6'h04,
    ST_XFER    = 6'h08,
    ST_WR_REQ  = 6'h10,
    ST_WR_WAIT = 6'h20
  } state_type;

endpackage

// *** core/block_copy_fill_engine.sv ***
// Block copy and block fill engine with its read buffer FIFO
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Read buffer: small FIFO with valid/ready on both sides
// ------------------------------------------------------------------
module read_buffer_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             push;
  logic             pop;

  // Flags come from the occupancy count, so full and empty are exact
  always_comb begin
    in_ready  = (count_reg != CNT_W'(DEPTH));
    out_valid = (count_reg != '0);
    out_data  = mem_reg[rd_ptr_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  end

  // Pointers and storage
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// Engine top
// ------------------------------------------------------------------
module block_copy_fill_engine (
  input  wire logic                                  clk,
  input  wire logic                                  reset,
  input  wire logic                                  cmd_valid,
  input  wire block_copy_pkg::cmd_type               cmd,
  output logic                                       cmd_ready,
  output logic                                       cmd_refused,
  output logic                                       busy,
  output logic                                       done,
  output logic                                       cache_rd_valid,
  output logic [block_copy_pkg::ADDR_W-1:0]          cache_rd_addr,
  input  wire logic                                  cache_rsp_valid,
  input  wire logic [block_copy_pkg::DATA_W-1:0]     cache_rsp_data,
  output logic                                       mem_req_valid,
  output block_copy_pkg::mem_req_type                mem_req,
  input  wire logic                                  mem_req_ready,
  input  wire logic                                  mem_rsp_valid,
  input  wire logic [block_copy_pkg::DATA_W-1:0]     mem_rsp_data
);
  localparam int AW = block_copy_pkg::ADDR_W;
  localparam int DW = block_copy_pkg::DATA_W;
  localparam int BW = block_copy_pkg::BEAT_W;
  localparam int OB = block_copy_pkg::OFFSET_BITS;

  block_copy_pkg::state_type   state_reg;
  block_copy_pkg::state_type   state_next;
  logic [BW-1:0]               beat_reg;
  logic [BW-1:0]               beat_next;
  logic [AW-1:0]               src_reg;
  logic [AW-1:0]               src_next;
  logic [AW-1:0]               dst_reg;
  logic [AW-1:0]               dst_next;
  logic                        src_cache_reg;
  logic                        src_cache_next;
  logic [DW-1:0]               wbuf_reg [block_copy_pkg::BEATS];
  logic [DW-1:0]               wbuf_next [block_copy_pkg::BEATS];
  logic                        cmd_ready_reg;
  logic                        cmd_ready_next;
  logic                        cmd_refused_reg;
  logic                        cmd_refused_next;
  logic                        busy_reg;
  logic                        busy_next;
  logic                        done_reg;
  logic                        done_next;
  logic                        cache_rd_valid_reg;
  logic                        cache_rd_valid_next;
  logic [AW-1:0]               cache_rd_addr_reg;
  logic [AW-1:0]               cache_rd_addr_next;
  logic                        mem_req_valid_reg;
  logic                        mem_req_valid_next;
  block_copy_pkg::mem_req_type mem_req_reg;
  block_copy_pkg::mem_req_type mem_req_next;
  logic                        take;
  logic                        rsp_valid;
  logic [DW-1:0]               rsp_data;
  logic                        rb_in_valid;
  logic                        rb_in_ready;
  logic                        rb_out_valid;
  logic                        rb_out_ready;
  logic [DW-1:0]               rb_out_data;

  // Address of one doubleword of a block; the low offset bits are dropped
  function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] base,
                                              input logic [BW-1:0] beat);
    beat_addr = {base[AW-1:OB], beat, block_copy_pkg::DW_ZERO};
  endfunction

  // Read data comes from whichever source the copy names
  always_comb begin
    rsp_valid = src_cache_reg ? cache_rsp_valid : mem_rsp_valid;
    rsp_data  = src_cache_reg ? cache_rsp_data : mem_rsp_data;
  end

  // Read buffer: filled by the source, drained only in the transfer phase,
  // so it is full only after the last read of a block and never stalls a read
  read_buffer_fifo #(
    .WIDTH (DW),
    .DEPTH (block_copy_pkg::RBUF_DEPTH)
  ) u_read_buffer (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (rb_in_valid),
    .in_ready  (rb_in_ready),
    .in_data   (rsp_data),
    .out_valid (rb_out_valid),
    .out_ready (rb_out_ready),
    .out_data  (rb_out_data)
  );

  // Sequencer next-state logic
  always_comb begin
    state_next          = state_reg;
    beat_next           = beat_reg;
    src_next            = src_reg;
    dst_next            = dst_reg;
    src_cache_next      = src_cache_reg;
    wbuf_next           = wbuf_reg;
    cmd_ready_next      = cmd_ready_reg;
    cmd_refused_next    = 1'b0;
    busy_next           = busy_reg;
    done_next           = 1'b0;
    cache_rd_valid_next = 1'b0;
    cache_rd_addr_next  = cache_rd_addr_reg;
    mem_req_valid_next  = mem_req_valid_reg && !mem_req_ready;
    mem_req_next        = mem_req_reg;
    rb_in_valid         = 1'b0;
    rb_out_ready        = 1'b0;
    take                = cmd_valid && cmd_ready_reg;
    case (state_reg)
      block_copy_pkg::ST_IDLE: begin
        // A command is taken in one cycle; a further command waits, cmd_ready low, until the move is done
        if (take) begin
          src_next       = cmd.src_addr;
          dst_next       = cmd.dst_addr;
          src_cache_next = cmd.src_cache;
          beat_next      = '0;
          if (!cmd.fill && !cmd.src_cache &&
              cmd.src_addr[AW-1:OB] == cmd.dst_addr[AW-1:OB]) begin
            cmd_refused_next = 1'b1;
          end else if (cmd.fill) begin
            // Fill skips reading and replicates the store's doubleword
            for (int i = 0; i < block_copy_pkg::BEATS; i++) begin
              wbuf_next[i] = cmd.pattern;
            end
            state_next     = block_copy_pkg::ST_WR_REQ;
            cmd_ready_next = 1'b0;
            busy_next      = 1'b1;
          end else begin
            state_next     = block_copy_pkg::ST_RD_REQ;
            cmd_ready_next = 1'b0;
            busy_next      = 1'b1;
          end
        end
      end
      block_copy_pkg::ST_RD_REQ: begin
        // One read outstanding; held off while the read buffer has no room
        if (rb_in_ready) begin
          if (src_cache_reg) begin
            cache_rd_valid_next = 1'b1;
            cache_rd_addr_next  = beat_addr(src_reg, beat_reg);
          end else begin
            mem_req_valid_next = 1'b1;
            mem_req_next.write = 1'b0;
            mem_req_next.addr  = beat_addr(src_reg, beat_reg);
            mem_req_next.data  = '0;
          end
          state_next = block_copy_pkg::ST_RD_WAIT;
        end
      end
      block_copy_pkg::ST_RD_WAIT: begin
        rb_in_valid = rsp_valid;
        if (rsp_valid && rb_in_ready) begin
          if (beat_reg == block_copy_pkg::LAST_BEAT) begin
            beat_next  = '0;
            state_next = block_copy_pkg::ST_XFER;
          end else begin
            beat_next  = beat_reg + 1'b1;
            state_next = block_copy_pkg::ST_RD_REQ;
          end
        end
      end
      block_copy_pkg::ST_XFER: begin
        // Whole block is in the read buffer before the write buffer loads
        rb_out_ready = 1'b1;
        if (rb_out_valid) begin
          wbuf_next[beat_reg] = rb_out_data;
          if (beat_reg == block_copy_pkg::LAST_BEAT) begin
            beat_next  = '0;
            state_next = block_copy_pkg::ST_WR_REQ;
          end else begin
            beat_next = beat_reg + 1'b1;
          end
        end
      end
      block_copy_pkg::ST_WR_REQ: begin
        mem_req_valid_next = 1'b1;
        mem_req_next.write = 1'b1;
        mem_req_next.addr  = beat_addr(dst_reg, beat_reg);
        mem_req_next.data  = wbuf_reg[beat_reg];
        state_next         = block_copy_pkg::ST_WR_WAIT;
      end
      block_copy_pkg::ST_WR_WAIT: begin
        // A write counts as complete when the bus accepts it
        if (mem_req_valid_reg && mem_req_ready) begin
          if (beat_reg == block_copy_pkg::LAST_BEAT) begin
            beat_next      = '0;
            state_next     = block_copy_pkg::ST_IDLE;
            busy_next      = 1'b0;
            cmd_ready_next = 1'b1;
            done_next      = 1'b1;
          end else begin
            beat_next  = beat_reg + 1'b1;
            state_next = block_copy_pkg::ST_WR_REQ;
          end
        end
      end
      default: begin
        state_next = block_copy_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; every output is one of these
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg          <= block_copy_pkg::ST_IDLE;
      beat_reg           <= '0;
      src_reg            <= '0;
      dst_reg            <= '0;
      src_cache_reg      <= 1'b0;
      cmd_ready_reg      <= 1'b1;
      cmd_refused_reg    <= 1'b0;
      busy_reg           <= 1'b0;
      done_reg           <= 1'b0;
      cache_rd_valid_reg <= 1'b0;
      cache_rd_addr_reg  <= '0;
      mem_req_valid_reg  <= 1'b0;
      mem_req_reg        <= '0;
      for (int i = 0; i < block_copy_pkg::BEATS; i++) begin
        wbuf_reg[i] <= '0;
      end
    end else begin
      state_reg          <= state_next;
      beat_reg           <= beat_next;
      src_reg            <= src_next;
      dst_reg            <= dst_next;
      src_cache_reg      <= src_cache_next;
      cmd_ready_reg      <= cmd_ready_next;
      cmd_refused_reg    <= cmd_refused_next;
      busy_reg           <= busy_next;
      done_reg           <= done_next;
      cache_rd_valid_reg <= cache_rd_valid_next;
      cache_rd_addr_reg  <= cache_rd_addr_next;
      mem_req_valid_reg  <= mem_req_valid_next;
      mem_req_reg        <= mem_req_next;
      wbuf_reg           <= wbuf_next;
    end
  end

  // Outputs straight from flip-flops
  assign cmd_ready      = cmd_ready_reg;
  assign cmd_refused    = cmd_refused_reg;
  assign busy           = busy_reg;
  assign done           = done_reg;
  assign cache_rd_valid = cache_rd_valid_reg;
  assign cache_rd_addr  = cache_rd_addr_reg;
  assign mem_req_valid  = mem_req_valid_reg;
  assign mem_req        = mem_req_reg;
endmodule

// *** bench/block_copy_fill_engine_chk.sv ***
// Checker of the block copy and fill engine ports
`timescale 1ns/1ps
module block_copy_fill_engine_chk (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic                        cmd_valid,
  input wire block_copy_pkg::cmd_type     cmd,
  input wire logic                        cmd_ready,
  input wire logic                        cmd_refused,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic                        cache_rd_valid,
  input wire logic [35:0]                 cache_rd_addr,
  input wire logic                        cache_rsp_valid,
  input wire logic [63:0]                 cache_rsp_data,
  input wire logic                        mem_req_valid,
  input wire block_copy_pkg::mem_req_type mem_req,
  input wire logic                        mem_req_ready,
  input wire logic                        mem_rsp_valid,
  input wire logic [63:0]                 mem_rsp_data
);
  logic        fill_reg;
  logic [35:0] dst_reg;
  logic [63:0] pat_reg;
  logic [2:0]  rsp_reg;

  // Remember the accepted command and count read answers since then
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_reg <= 1'b0;
      rsp_reg  <= 3'h0;
    end else if (cmd_valid && cmd_ready) begin
      fill_reg <= cmd.fill;
      dst_reg  <= cmd.dst_addr;
      pat_reg  <= cmd.pattern;
      rsp_reg  <= 3'h0;
    end else if (busy && (mem_rsp_valid || cache_rsp_valid)) begin
      rsp_reg <= rsp_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_start_cause: assert property ($rose(busy) |-> $past(cmd_valid && cmd_ready))
    else $error("busy rose without an accepted command");
  a_accept_answer: assert property (cmd_valid && cmd_ready |=> busy != cmd_refused)
    else $error("accepted command got no single answer");
  a_busy_blocks: assert property (busy |-> !cmd_ready)
    else $error("ready while busy");
  a_done_ends: assert property ($fell(busy) |-> done && cmd_ready)
    else $error("busy fell without done");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_refuse_idle: assert property (cmd_refused |-> !busy && !mem_req_valid)
    else $error("refused command started work");
  a_fill_writes: assert property (mem_req_valid && fill_reg |->
    mem_req.write && mem_req.data == pat_reg)
    else $error("fill request not a pattern write");
  a_fill_no_cache: assert property (busy && fill_reg |-> !cache_rd_valid)
    else $error("cache read during fill");
  a_write_block: assert property (mem_req_valid && mem_req.write |->
    mem_req.addr[35:5] == dst_reg[35:5] && mem_req.addr[2:0] == 3'h0)
    else $error("write outside destination block");
  a_reads_first: assert property (mem_req_valid && mem_req.write && !fill_reg |->
    rsp_reg == 3'h4)
    else $error("copy write before four reads");
  a_req_held: assert property (mem_req_valid && !mem_req_ready |=>
    mem_req_valid && $stable(mem_req))
    else $error("bus request dropped or changed");
endmodule

bind block_copy_fill_engine block_copy_fill_engine_chk chk (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
  .busy(busy), .done(done), .cache_rd_valid(cache_rd_valid), .cache_rd_addr(cache_rd_addr),
  .cache_rsp_valid(cache_rsp_valid), .cache_rsp_data(cache_rsp_data),
  .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
  .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

// *** bench/mem_model.sv ***
// Main memory model answering engine requests on the system bus
`timescale 1ns/1ps
module mem_model (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic [3:0]                  lat,
  input wire logic                        mem_req_valid,
  input wire block_copy_pkg::mem_req_type mem_req,
  output logic                            mem_req_ready = 1'b0,
  output logic                            mem_rsp_valid = 1'b0,
  output logic [63:0]                     mem_rsp_data = 64'h0
);
  logic [63:0] store [logic [35:0]];
  logic [35:0] raddr;
  int          wcnt;
  int          rcnt;
  int          n_rd;
  int          n_wr;

  // One request at a time; ready after lat waits, read data lat+1 cycles after acceptance
  always @(posedge clk) begin
    mem_rsp_valid <= 1'b0;
    mem_rsp_data  <= ~mem_rsp_data;  // Idle data never repeats the last word
    if (reset) begin
      mem_req_ready <= 1'b0;
      wcnt = 0;
      rcnt = 0;
    end else if (mem_req_valid && mem_req_ready) begin
      mem_req_ready <= 1'b0;
      wcnt = 0;
      if (mem_req.write) begin
        store[mem_req.addr] = mem_req.data;
        n_wr++;
      end else begin
        raddr = mem_req.addr;
        rcnt = lat + 1;
        n_rd++;
      end
    end else if (rcnt > 0) begin
      rcnt--;
      if (rcnt == 0) begin
        mem_rsp_valid <= 1'b1;
        mem_rsp_data  <= store[raddr];
      end
    end else if (mem_req_valid) begin
      if (wcnt >= lat) mem_req_ready <= 1'b1;
      wcnt++;
    end
  end
endmodule

// *** bench/block_copy_fill_engine_tb.sv ***
// Self-checking testbench of the block copy and fill engine
`timescale 1ns/1ps
module block_copy_fill_engine_tb;
  logic                        clk = 1'b0;
  logic                        reset = 1'b1;
  logic                        cmd_valid = 1'b0;
  block_copy_pkg::cmd_type     cmd = '0;
  logic                        cmd_ready, cmd_refused, busy, done, cache_rd_valid;
  logic                        mem_req_valid, mem_req_ready, mem_rsp_valid;
  logic                        cache_rsp_valid = 1'b0;
  logic                        cp = 1'b0;
  logic [35:0]                 cache_rd_addr, ca;
  logic [63:0]                 cache_rsp_data = 64'h0;
  logic [63:0]                 mem_rsp_data;
  logic [3:0]                  lat = 4'h0;
  block_copy_pkg::mem_req_type mem_req;
  int                          n_errors = 0;
  int                          num_checks = 0;
  int                          rd0, wr0;

  always #5 clk = ~clk;

  block_copy_fill_engine uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .busy(busy), .done(done),
    .cache_rd_valid(cache_rd_valid), .cache_rd_addr(cache_rd_addr),
    .cache_rsp_valid(cache_rsp_valid), .cache_rsp_data(cache_rsp_data),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));
  mem_model mem (.clk(clk), .reset(reset), .lat(lat), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data));

  // Cache answers two cycles after a read pulse; idle data drifts
  always @(negedge clk) begin
    cp <= cache_rd_valid;
    ca <= cache_rd_addr;
    cache_rsp_valid <= cp;
    cache_rsp_data <= cp ? {28'hCAC0DE0, ca} : ~cache_rsp_data;
  end

  function automatic logic [35:0] dw(input logic [35:0] a, input int i);
    return {a[35:5], 2'(i), 3'h0};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Offers one command at an idle engine; only the bench ever starts work
  task automatic issue(input logic f, input logic sc, input logic [35:0] s, input logic [35:0] d,
                       input logic [63:0] p);
    rd0 = mem.n_rd;
    wr0 = mem.n_wr;
    cmd_valid = 1'b1;
    cmd = '{f, sc, s, d, p};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  // Bounded wait for done, then idle state with command port open again
  task automatic wait_done();
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      n_errors++;
      test_done();
    end
    chk({busy, cmd_ready}, 64'h1);
  endtask

  task automatic test_fill();
    issue(1'b1, 1'b0, 36'h0, 36'h10000001F, 64'h0123456789ABCDEF);
    chk(busy, 64'h1);
    // Let an edge pass so the valid line is not lowered and raised in one step
    @(negedge clk);
    cmd_valid = 1'b1;  // A second command while busy must be ignored
    cmd.pattern = 64'hFFFF0000FFFF0000;
    repeat (2) @(negedge clk);
    chk(cmd_ready, 64'h0);
    cmd_valid = 1'b0;
    wait_done();
    for (int i = 0; i < 4; i++) begin
      chk(mem.store[dw(36'h100000000, i)], 64'h0123456789ABCDEF);
    end
    chk(mem.n_rd - rd0, 64'h0);
    chk(mem.n_wr - wr0, 64'h4);
    $display("test_fill ended");
  endtask

  task automatic test_copy_mem();
    lat = 4'h3;
    for (int i = 0; i < 4; i++) mem.store[dw(36'h300000040, i)] = 64'hA5A5000000000000 + i;
    issue(1'b0, 1'b0, 36'h300000055, 36'h3000000A0, 64'h1111111111111111);
    chk(busy, 64'h1);
    wait_done();
    for (int i = 0; i < 4; i++) begin
      chk(mem.store[dw(36'h3000000A0, i)], 64'hA5A5000000000000 + i);
    end
    chk(mem.n_rd - rd0, 64'h4);
    chk(mem.n_wr - wr0, 64'h4);
    $display("test_copy_mem ended");
  endtask

  task automatic test_copy_cache();
    lat = 4'h1;
    issue(1'b0, 1'b1, 36'h400000047, 36'h500000000, 64'h0);
    wait_done();
    for (int i = 0; i < 4; i++) begin
      chk(mem.store[dw(36'h500000000, i)], {28'hCAC0DE0, dw(36'h400000040, i)});
    end
    chk(mem.n_rd - rd0, 64'h0);
    $display("test_copy_cache ended");
  endtask

  task automatic test_refuse();
    issue(1'b0, 1'b0, 36'h200000100, 36'h200000108, 64'h0);
    chk({cmd_refused, busy}, 64'h2);
    repeat (8) @(negedge clk);
    chk(mem.n_rd + mem.n_wr - rd0 - wr0, 64'h0);
    chk({cmd_refused, cmd_ready}, 64'h1);
    $display("test_refuse ended");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk({busy, cmd_ready, done, mem_req_valid}, 64'h4);
    test_fill();
    test_copy_mem();
    test_copy_cache();
    test_refuse();
    test_done();
  end
endmodule
